// >>> verilog/uft_pkg.sv
package uft_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int BAUD_W = 12;
    // register offsets
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_CSA = 3'h1;
    localparam logic [2:0] OFF_CSB = 3'h2;
    localparam logic [2:0] OFF_CSC = 3'h3;
    localparam logic [2:0] OFF_BAUD_LO = 3'h4;
    localparam logic [2:0] OFF_BAUD_HI = 3'h5;
    localparam logic [2:0] OFF_CLKDIR = 3'h6;
    // control_status_a fields
    localparam int CSA_DOUBLE = 1;
    localparam int CSA_UDRE = 5;
    localparam int CSA_TXC = 6;
    // control_status_b fields
    localparam int CSB_TX9 = 0;
    localparam int CSB_SIZE2 = 2;
    localparam int CSB_TRANSMIT_ENABLE_BIT = 3;
    // control_status_c fields
    localparam int CSC_POL = 0;
    localparam int CSC_SIZE_LO = 1;
    localparam int CSC_STOP = 3;
    localparam int CSC_PAR_LO = 4;
    localparam int CSC_SYNC = 6;
    // clock pin direction field
    localparam int CLKDIR_MASTER = 0;
    // reset values
    localparam logic [2:0] RST_SIZE = 3'h3;
    localparam logic [1:0] RST_PARITY = 2'h0;
    localparam logic [BAUD_W-1:0] RST_BAUD = 12'h000;
    // encodings
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;
    // last sub-tick of a bit in the two asynchronous speeds
    localparam logic [3:0] DIV_NORMAL_LAST = 4'hf;
    localparam logic [3:0] DIV_DOUBLE_LAST = 4'h7;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_START = 6'h02,
        ST_DATA = 6'h04,
        ST_PARITY = 6'h08,
        ST_STOP1 = 6'h10,
        ST_STOP2 = 6'h20
    } uft_tx_state_e;
endpackage

// >>> verilog/uft_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
module uft_baud_gen (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [uft_pkg::BAUD_W-1:0] i_divisor,
    input wire logic i_reload,
    input wire logic i_double,
    input wire logic i_sync_master,
    input wire logic i_pol,
    output logic o_bit_tick,
    output logic o_xck
);
    import uft_pkg::*;

    typedef struct packed {
        logic [BAUD_W-1:0] cnt;
        logic [3:0] sub;
        logic xck;
        logic tick;
    } uft_baud_s;

    uft_baud_s q;
    uft_baud_s d;
    logic zero;
    logic [3:0] last;

    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        zero = (q.cnt == '0);
        last = i_double ? DIV_DOUBLE_LAST : DIV_NORMAL_LAST;
        // down-counter reloads on zero or on a write of the divisor low byte
        if (zero || i_reload)
        begin
            d.cnt = i_divisor;
        end
        else
        begin
            d.cnt = q.cnt - 1'b1;
        end
        if (!i_sync_master)
        begin
            d.xck = i_pol;
        end
        if (zero)
        begin
            if (i_sync_master)
            begin
                // divide by 2: toggle the clock, shift on the change edge
                d.xck = ~q.xck; // RULE20
                d.tick = (q.xck == i_pol); // RULE21
            end
            else if (q.sub >= last)
            begin
                d.sub = 4'h0;
                d.tick = 1'b1; // RULE20
            end
            else
            begin
                d.sub = q.sub + 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_bit_tick = q.tick;
    assign o_xck = q.xck;
endmodule
`default_nettype wire

// >>> verilog/uft_clk_edge.sv
`timescale 1ns/1ps
`default_nettype none
module uft_clk_edge (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_xck_pin,
    input wire logic i_pol,
    output logic o_change
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic change;
    } uft_edge_s;

    uft_edge_s q;
    uft_edge_s d;

    always_comb
    begin
        d = q;
        // two-flop synchroniser, edge taken from the second stage and the delayed copy after it
        d.meta = i_xck_pin;
        d.sync = q.meta;
        d.prev = q.sync;
        d.change = i_pol ? (q.prev & ~q.sync) : (~q.prev & q.sync); // RULE21
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_change = q.change;
endmodule
`default_nettype wire

// >>> verilog/uft_transmitter.sv
// Summary of operation
// RULE1: all 30 formats: 1 start, 5-9 data, none/even/odd parity, 1-2 stops.
// RULE2: start bit first, then data bits least significant first.
// RULE3: parity bit sits after the last data bit, before the first stop.
// RULE4: after a frame, start the next at once or hold the line high.
// RULE5: start bit is always low, every stop bit always high.
// RULE6: one format setting shared with the receiver; changing it corrupts transfers.
// RULE7: 3-bit size field, 2-bit parity field, 1-bit stop count selector.
// RULE8: receiver ignores the second stop bit; frame error from first stop only.
// RULE9: parity is xor of data bits; inverted for odd parity.
// RULE10: transmit enable takes the serial output pin over from the port.
// RULE11: synchronous mode with transmit enabled takes the clock pin for timing.
// RULE12: writing the data register loads the buffer and starts transmission.
// RULE13: buffer moves to shifter when idle or right after the last stop.
// RULE14: shifter sends a frame at baud/double-speed rate or external clock.
// RULE15: below eight bits the unused upper written bits are ignored.
// RULE16: nine-bit size code 7; ninth bit written before the low byte.
// RULE17: buffer-empty flag reports the buffer state; host polls it.
// RULE18: host sets rate, mode and format before sending, not during.
// RULE19: transmit complete flag marks all done; host clears it before writing.
// RULE20: baud output divided by 16 normal, 8 double speed, 2 sync master.
// RULE21: polarity 0 changes data on rising clock edge; polarity 1 reverses.
// RULE22: every bit lasts one bit period; start aligned to a period boundary.
// RULE23: parity covers only the configured data bits.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module uft_transmitter (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [uft_pkg::ADDR_W-1:0] i_addr,
    input wire logic [uft_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [uft_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_xck,
    output logic o_xck,
    output logic o_xck_oe,
    output logic o_txd,
    output logic o_txd_oe,
    output logic o_buffer_empty,
    output logic o_tx_complete,
    output logic [2:0] o_fmt_char_size,
    output logic [1:0] o_fmt_parity,
    output logic o_fmt_two_stop
);
    import uft_pkg::*;

    typedef struct packed {
        uft_tx_state_e st;
        logic [8:0] sh;
        logic [3:0] cnt;
        logic par;
        logic line;
        logic [8:0] buf_data;
        logic udre;
        logic txc;
        logic transmit_enable_bit;
        logic tx9;
        logic dbl;
        logic [2:0] size;
        logic [1:0] pmode;
        logic two_stop;
        logic sync;
        logic pol;
        logic master;
        logic [BAUD_W-1:0] ubrr;
        logic reload;
        logic [DATA_W-1:0] rdata;
        logic oe;
        logic xck_oe;
    } uft_main_s;

    uft_main_s q;
    uft_main_s d;
    logic bg_tick;
    logic edge_tick;
    logic tick;
    logic [3:0] nbits;
    logic [8:0] mask;
    logic [8:0] loaded;
    logic par_on;
    logic frame_end;

    uft_baud_gen u_baud (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_divisor(q.ubrr),
        .i_reload(q.reload),
        .i_double(q.dbl),
        .i_sync_master(q.sync & q.master),
        .i_pol(q.pol),
        .o_bit_tick(bg_tick),
        .o_xck(o_xck)
    );

    uft_clk_edge u_edge (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_xck_pin(i_xck),
        .i_pol(q.pol),
        .o_change(edge_tick)
    );

    // bit-period strobe from the active clock source
    assign tick = (q.sync && !q.master) ? edge_tick : bg_tick; // RULE14

    always_comb
    begin
        unique case (q.size) // RULE7
            3'h0: nbits = 4'h5;
            3'h1: nbits = 4'h6;
            3'h2: nbits = 4'h7;
            SIZE_NINE: nbits = 4'h9;
            default: nbits = 4'h8;
        endcase
    end

    // one mask bit per data position
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++)
        begin : g_mask
            assign mask[gi] = (4'(gi) < nbits); // RULE15
        end
    endgenerate

    assign loaded = q.buf_data & mask; // RULE15 RULE23
    assign par_on = q.pmode[1]; // RULE3

    always_comb
    begin
        d = q;
        d.reload = 1'b0;
        frame_end = 1'b0;
        // frame engine, advanced once per bit period
        if (tick)
        begin
            unique case (q.st)
                ST_IDLE:
                begin
                    d.line = 1'b1; // RULE4
                    if (!q.udre && (q.transmit_enable_bit || q.oe))
                    begin
                        d.st = ST_START; // RULE13 RULE22
                    end
                end
                ST_START:
                begin
                    d.line = q.sh[0]; // RULE2
                    d.sh = {1'b0, q.sh[8:1]};
                    d.cnt = 4'h1;
                    d.st = ST_DATA;
                end
                ST_DATA:
                begin
                    if (q.cnt < nbits) // RULE1
                    begin
                        d.line = q.sh[0]; // RULE2
                        d.sh = {1'b0, q.sh[8:1]};
                        d.cnt = q.cnt + 1'b1;
                    end
                    else if (par_on)
                    begin
                        d.line = q.par; // RULE3
                        d.st = ST_PARITY;
                    end
                    else
                    begin
                        d.line = 1'b1; // RULE5
                        d.st = ST_STOP1;
                    end
                end
                ST_PARITY:
                begin
                    d.line = 1'b1; // RULE5
                    d.st = ST_STOP1;
                end
                ST_STOP1:
                begin
                    if (q.two_stop) // RULE1
                    begin
                        d.line = 1'b1; // RULE5
                        d.st = ST_STOP2;
                    end
                    else
                    begin
                        frame_end = 1'b1;
                    end
                end
                ST_STOP2:
                begin
                    frame_end = 1'b1;
                end
            endcase
            // back-to-back frame or idle high after the last stop
            if (frame_end)
            begin
                if (!q.udre)
                begin
                    d.st = ST_START; // RULE4 RULE13
                end
                else
                begin
                    d.line = 1'b1; // RULE4
                    d.st = ST_IDLE;
                end
            end
            if (d.st == ST_START)
            begin
                d.sh = loaded; // RULE13
                d.par = (^loaded) ^ (q.pmode == PAR_ODD); // RULE9 RULE23
                d.line = 1'b0; // RULE5
                d.udre = 1'b1; // RULE17
            end
        end
        // register reads, data valid one cycle later
        d.rdata = '0;
        if (i_rd)
        begin
            unique case (i_addr)
                OFF_CSA:
                begin
                    d.rdata[CSA_DOUBLE] = q.dbl;
                    d.rdata[CSA_UDRE] = q.udre; // RULE17
                    d.rdata[CSA_TXC] = q.txc; // RULE19
                end
                OFF_CSB:
                begin
                    d.rdata[CSB_TX9] = q.tx9;
                    d.rdata[CSB_SIZE2] = q.size[2];
                    d.rdata[CSB_TRANSMIT_ENABLE_BIT] = q.transmit_enable_bit;
                end
                OFF_CSC:
                begin
                    d.rdata[CSC_POL] = q.pol;
                    d.rdata[CSC_SIZE_LO +: 2] = q.size[1:0];
                    d.rdata[CSC_STOP] = q.two_stop;
                    d.rdata[CSC_PAR_LO +: 2] = q.pmode;
                    d.rdata[CSC_SYNC] = q.sync;
                end
                OFF_BAUD_LO: d.rdata = q.ubrr[7:0];
                OFF_BAUD_HI: d.rdata = {4'h0, q.ubrr[11:8]};
                OFF_CLKDIR: d.rdata[CLKDIR_MASTER] = q.master;
                default: d.rdata = '0;
            endcase
        end
        // register writes
        if (i_wr)
        begin
            unique case (i_addr)
                OFF_DATA:
                begin
                    d.buf_data = {q.tx9, i_wdata}; // RULE12 RULE16
                    d.udre = 1'b0; // RULE12
                end
                OFF_CSA:
                begin
                    d.dbl = i_wdata[CSA_DOUBLE];
                    if (i_wdata[CSA_TXC])
                    begin
                        d.txc = 1'b0; // RULE19
                    end
                end
                OFF_CSB:
                begin
                    d.tx9 = i_wdata[CSB_TX9]; // RULE16
                    d.size[2] = i_wdata[CSB_SIZE2]; // RULE7
                    d.transmit_enable_bit = i_wdata[CSB_TRANSMIT_ENABLE_BIT];
                end
                OFF_CSC:
                begin
                    d.pol = i_wdata[CSC_POL];
                    d.size[1:0] = i_wdata[CSC_SIZE_LO +: 2]; // RULE7
                    d.two_stop = i_wdata[CSC_STOP]; // RULE7
                    d.pmode = i_wdata[CSC_PAR_LO +: 2]; // RULE7
                    d.sync = i_wdata[CSC_SYNC];
                end
                OFF_BAUD_LO:
                begin
                    d.ubrr[7:0] = i_wdata;
                    d.reload = 1'b1;
                end
                OFF_BAUD_HI: d.ubrr[11:8] = i_wdata[3:0];
                OFF_CLKDIR: d.master = i_wdata[CLKDIR_MASTER];
                default: d.reload = 1'b0;
            endcase
        end
        // completion set wins over a clear in the same cycle
        if (tick && frame_end && q.udre)
        begin
            d.txc = 1'b1; // RULE19
        end
        // pin override holds until pending work is sent
        d.oe = d.transmit_enable_bit | (d.st != ST_IDLE) | (q.oe & !d.udre); // RULE10
        d.xck_oe = d.sync & d.master & d.oe; // RULE11
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.line <= 1'b1;
            q.udre <= 1'b1;
            q.size <= RST_SIZE;
            q.pmode <= RST_PARITY;
            q.ubrr <= RST_BAUD;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_rdata = q.rdata;
    assign o_txd = q.line;
    assign o_txd_oe = q.oe;
    assign o_xck_oe = q.xck_oe;
    assign o_buffer_empty = q.udre;
    assign o_tx_complete = q.txc;
    // live format shared with the receiver; it checks only the first stop
    assign o_fmt_char_size = q.size; // RULE6
    assign o_fmt_parity = q.pmode; // RULE6
    assign o_fmt_two_stop = q.two_stop; // RULE8

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    sequence seq_leave_start;
        (q.st == ST_START) && tick;
    endsequence

    sequence seq_last_stop_no_data;
        tick && q.udre && ((q.st == ST_STOP2) || ((q.st == ST_STOP1) && !q.two_stop));
    endsequence

    chk_start_low: assert property ($rose(q.st == ST_START) |-> !o_txd) // RULE5
        else $error("start bit not low");
    chk_stop_high: assert property ((q.st == ST_STOP1) || (q.st == ST_STOP2) |-> o_txd) // RULE5
        else $error("stop bit not high");
    chk_lsb_first: assert property (seq_leave_start |=> o_txd == $past(q.sh[0])) // RULE2
        else $error("first data bit is not the lsb");
    chk_parity_order: assert property ($rose(q.st == ST_PARITY) |-> $past(q.st == ST_DATA)) // RULE3
        else $error("parity not right after data");
    chk_parity_value: assert property ((q.st == ST_PARITY) |-> o_txd == q.par) // RULE9
        else $error("parity bit value wrong");
    chk_buffer_write: assert property (i_wr && (i_addr == OFF_DATA) |=> !o_buffer_empty) // RULE12
        else $error("data write did not fill buffer");
    chk_complete_set: assert property (seq_last_stop_no_data |=> o_tx_complete && (q.st == ST_IDLE)) // RULE19
        else $error("complete flag not set");
    chk_idle_high: assert property ((q.st == ST_IDLE) |-> o_txd) // RULE4
        else $error("idle line not high");
    chk_pin_takeover: assert property (q.transmit_enable_bit |-> o_txd_oe) // RULE10
        else $error("serial pin not taken over");
    chk_bit_hold: assert property (!tick && !$past(tick) |=> $stable(o_txd)) // RULE22
        else $error("line changed between bit periods");
endmodule
`default_nettype wire

// >>> testbench/uft_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module uft_rx_model (
    input wire logic i_ref_clk,
    input wire logic i_line,
    input wire logic [15:0] i_period,
    input wire logic [3:0] i_bits,
    output logic [12:0] o_frame,
    output logic o_got
);
    initial
    begin
        o_frame = 13'h1fff;
        o_got = 1'b0;
    end
    // wait for a start edge, then sample each bit in its middle
    always
    begin
        @(negedge i_line);
        o_frame = 13'h1fff;
        repeat (i_period / 2) @(posedge i_ref_clk);
        for (int k = 0; k < i_bits; k++)
        begin
            o_frame[k] = i_line;
            if (k + 1 < i_bits)
                repeat (i_period) @(posedge i_ref_clk);
        end
        @(posedge i_ref_clk);
        o_got <= 1'b1;
        @(posedge i_ref_clk);
        o_got <= 1'b0;
    end
endmodule
`default_nettype wire

// >>> testbench/uft_transmitter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module uft_transmitter_tb;
    import uft_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_xck = 1'b0;
    logic [7:0] o_rdata;
    logic o_xck, o_xck_oe, o_txd, o_txd_oe, o_buffer_empty, o_tx_complete;
    logic [2:0] o_fmt_char_size;
    logic [1:0] o_fmt_parity;
    logic o_fmt_two_stop;
    logic [15:0] per = 16'h0010;
    logic [3:0] nb = 4'ha;
    logic [12:0] frame;
    logic got;
    wire logic line = o_txd_oe ? o_txd : 1'b1;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int t_last = 0;
    logic gap_on = 1'b0;
    logic pol = 1'b0;
    logic slave_on = 1'b0;
    int hp = 4;
    logic [12:0] exp_q [$];
    logic [12:0] ef;
    logic [2:0] sz;
    logic [1:0] pm;
    logic two, dbl;
    logic [11:0] dv;
    logic [7:0] rd;
    logic [2:0] szs [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};

    uft_transmitter uft_transmitter_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_xck(i_xck), .o_xck(o_xck), .o_xck_oe(o_xck_oe), .o_txd(o_txd),
        .o_txd_oe(o_txd_oe), .o_buffer_empty(o_buffer_empty),
        .o_tx_complete(o_tx_complete), .o_fmt_char_size(o_fmt_char_size),
        .o_fmt_parity(o_fmt_parity), .o_fmt_two_stop(o_fmt_two_stop));
    uft_rx_model uft_rx_model_inst (.i_ref_clk(i_ref_clk), .i_line(line),
        .i_period(per), .i_bits(nb), .o_frame(frame), .o_got(got));

    always #2.5 i_ref_clk = ~i_ref_clk;

    // external clock for the slave scenario, runs only while that test is on
    always
    begin
        repeat (hp) @(posedge i_ref_clk);
        if (slave_on)
            i_xck <= ~i_xck;
    end

    function automatic int nbits(logic [2:0] s);
        return s == 3'h7 ? 9 : (s > 3'h3 ? 8 : 5 + s);
    endfunction
    function automatic int flen();
        return 2 + nbits(sz) + pm[1] + two;
    endfunction
    function automatic logic [12:0] mkframe(logic [8:0] d);
        logic [12:0] f;
        int n;
        logic p;
        f = 13'h1fff;
        n = nbits(sz);
        p = pm[0];
        f[0] = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            f[1 + i] = d[i];
            p = p ^ d[i];
        end
        if (pm[1])
            f[1 + n] = p;
        return f;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdreg(logic [2:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask
    task automatic cfg(logic sync, logic mst);
        wr(OFF_BAUD_HI, {4'h0, dv[11:8]});
        wr(OFF_BAUD_LO, dv[7:0]);
        wr(OFF_CSA, {6'h00, dbl, 1'b0});
        wr(OFF_CLKDIR, {7'h00, mst});
        wr(OFF_CSC, {1'b0, sync, pm, two, sz[1:0], pol});
        wr(OFF_CSB, {4'h0, 1'b1, sz[2], 2'h0});
        per = sync ? 16'(mst ? 2 * (dv + 1) : 2 * hp) : 16'((dbl ? 8 : 16) * (dv + 1));
        nb = 4'(flen());
        @(posedge i_ref_clk);
        #1;
        `CHK("fmt", {sz, pm, two}, {o_fmt_char_size, o_fmt_parity, o_fmt_two_stop})
        `CHK("txd_oe", 1'b1, o_txd_oe)
    endtask
    task automatic send(logic [8:0] d);
        int k;
        k = 0;
        rdreg(OFF_CSA, rd);
        while (rd[CSA_UDRE] !== 1'b1 && k < 400)
        begin
            rdreg(OFF_CSA, rd);
            k++;
        end
        `CHK("empty_wait", 1'b1, rd[CSA_UDRE])
        if (k == 400)
            summarize();
        wr(OFF_CSA, {2'h1, 4'h0, dbl, 1'b0});
        wr(OFF_CSB, {4'h0, 1'b1, sz[2], 1'b0, d[8]});
        wr(OFF_DATA, d[7:0]);
        exp_q.push_back(mkframe(d));
        #1;
        `CHK("buf_full", 1'b0, o_buffer_empty)
    endtask
    task automatic wait_done();
        int k;
        for (k = 0; k < 3000 && o_tx_complete !== 1'b1; k++)
        begin
            @(posedge i_ref_clk);
            #1;
        end
        `CHK("complete", 1'b1, o_tx_complete)
        if (k == 3000)
            summarize();
        `CHK("drained", 0, exp_q.size())
    endtask

    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        if (got === 1'b1)
        begin
            ef = exp_q.size() > 0 ? exp_q.pop_front() : 13'h0000;
            `CHK("frame", ef, frame)
            if (gap_on && t_last > 0)
                `CHK("spacing", flen() * per, cyc - t_last)
            t_last = cyc;
        end
    end

    initial
    begin
        repeat (100000) @(posedge i_ref_clk);
        `CHK("watchdog", 1'b0, 1'b1)
        summarize();
    end

    initial
    begin
        int k;
        logic p;
        void'($urandom(32'h8e6324b9));
        repeat (20) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        #1;
        `CHK("txd_idle", 2'b10, {o_txd, o_txd_oe})
        `CHK("fmt_rst", {RST_SIZE, RST_PARITY, 1'b0}, {o_fmt_char_size, o_fmt_parity,
            o_fmt_two_stop})
        rdreg(OFF_CSA, rd);
        `CHK("csa_rst", 8'h20, rd)
        rdreg(3'h7, rd);
        `CHK("unmapped", 8'h00, rd)
        $display("reset test done");
        for (int a = 0; a < 5; a++)
            for (int b = 0; b < 3; b++)
                for (int c = 0; c < 2; c++)
                begin
                    sz = szs[a];
                    pm = b == 0 ? 2'h0 : (b == 1 ? PAR_EVEN : PAR_ODD);
                    two = c[0];
                    dbl = 1'($urandom_range(1, 0));
                    dv = 12'($urandom_range(1, 0));
                    cfg(1'b0, 1'b0);
                    send(9'($urandom_range(511, 0)));
                    wait_done();
                end
        $display("format test done");
        sz = 3'h5;
        pm = PAR_ODD;
        two = 1'b1;
        dbl = 1'b0;
        dv = 12'h000;
        cfg(1'b0, 1'b0);
        t_last = 0;
        gap_on = 1'b1;
        send(9'h1ff);
        send(9'h000);
        send(9'h0a5);
        wait_done();
        gap_on = 1'b0;
        rdreg(OFF_CSA, rd);
        `CHK("csa_done", 8'h60, rd)
        wr(OFF_CSA, 8'h40);
        rdreg(OFF_CSA, rd);
        `CHK("csa_clear", 8'h20, rd)
        $display("burst test done");
        sz = 3'h3;
        pm = 2'h0;
        two = 1'b0;
        dv = 12'h001;
        cfg(1'b1, 1'b1);
        `CHK("xck_oe", 1'b1, o_xck_oe)
        k = 0;
        p = o_xck;
        repeat (16)
        begin
            @(posedge i_ref_clk);
            #1;
            if (o_xck !== p)
                k++;
            p = o_xck;
        end
        `CHK("xck_toggles", 8, k)
        send(9'($urandom_range(255, 0)));
        wr(OFF_CSB, 8'h00);
        #1;
        `CHK("oe_hold", 1'b1, o_txd_oe)
        wait_done();
        repeat (2) @(posedge i_ref_clk);
        #1;
        `CHK("oe_off", 2'b10, {o_txd, o_txd_oe})
        $display("sync test done");
        pol = 1'b1;
        sz = 3'h2;
        pm = PAR_EVEN;
        two = 1'b1;
        slave_on = 1'b1;
        cfg(1'b1, 1'b0);
        `CHK("xck_slave", 2'b10, {o_xck, o_xck_oe})
        send(9'($urandom_range(511, 0)));
        wait_done();
        slave_on = 1'b0;
        $display("slave test done");
        summarize();
    end
endmodule
`default_nettype wire
